// ===== hdl/sci_tx_pkg.sv
// Package for the serial transmit status and receiver standby block.
// Assumes an APB slave with 32-bit data; registers are 8 bits in the low byte.
package sci_tx_pkg;
  // Register byte addresses
  localparam logic [7:0] addr_control_two = 8'h00;
  localparam logic [7:0] addr_status_one = 8'h04;
  localparam logic [7:0] addr_data = 8'h08;
  localparam logic [7:0] addr_control_one = 8'h0c;
  localparam logic [7:0] addr_baud = 8'h10;
  localparam logic [7:0] addr_irq_status = 8'h14;
  localparam logic [7:0] addr_irq_enable = 8'h18;
  localparam logic [7:0] addr_irq_clear = 8'h1c;
  // Control two fields
  localparam int tx_enable_pos = 3;
  localparam int rx_enable_pos = 2;
  localparam int standby_pos = 1;
  localparam int break_pos = 0;
  // Control one fields
  localparam int long_frame_pos = 4;
  localparam int resume_method_pos = 3;
  // Status one fields
  localparam int buf_empty_pos = 7;
  localparam int complete_pos = 6;
  localparam int idle_pos = 4;
  // Interrupt status fields
  localparam int ev_buf_empty = 0;
  localparam int ev_complete = 1;
  localparam int ev_wakeup = 2;
  // Reset values
  localparam logic [7:0] baud_reset = 8'h04;
  localparam logic [7:0] status_reset = 8'hc0;
  // Frame lengths in bit times: short and long frame
  localparam logic [3:0] frame_short = 4'ha;
  localparam logic [3:0] frame_long = 4'hb;
  // Idle bit times that make an idle line
  localparam logic [3:0] idle_bits = 4'ha;
  typedef enum logic [1:0] {
    tx_idle = 2'b00,
    tx_data = 2'b01,
    tx_preamble = 2'b10,
    tx_break = 2'b11
  } tx_state_t;
endpackage

// ===== hdl/sci_tx_status.sv
// Transmit status, break queuing and receiver standby logic of a serial port.
// Assumes an APB master on pclk; txd and rxd are synchronous to pclk.
// Summary of operation
// - Writing one puts receiver in standby
// - Resume method: idle line or MSB mark
// - Hardware clears standby bit on wakeup
// - Break bit one then zero queues break
// - Breaks repeat while bit held; 10/11 bits
// - Second break may queue before clearing
// - Status register read only; writes ignored
// - Buffer empty at reset and on shifter load
// - Buffer empty clears on status read, data write
// - Complete set when empty, transmitter idle and no break queued
// - Complete clears on read then qualifying action
// - Transmit enable rising edge queues preamble
module sci_tx_status (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  output logic txd,
  output logic irq,
  output logic rx_standby
);
  logic [7:0] control_two;
  logic [7:0] control_one;
  logic [7:0] baud;
  logic [7:0] data_buf;
  logic tx_buffer_empty;
  logic tx_complete_flag;
  logic buf_armed;
  logic complete_armed;
  logic [2:0] irq_status;
  logic [2:0] irq_enable;
  sci_tx_pkg::tx_state_t tx_state;
  logic [8:0] shifter;
  logic [3:0] bit_cnt;
  logic [7:0] baud_cnt;
  logic break_latched;
  logic [3:0] rx_cnt;
  logic [7:0] rx_baud_cnt;
  logic rx_busy;
  logic [3:0] idle_cnt;
  logic rx_msb;
  logic rx_prev;
  logic wakeup;
  logic wr_en;
  logic rd_en;
  logic status_read;
  logic data_write;
  logic tx_en_rise;
  logic break_write_one;
  logic load_shifter;
  logic bit_tick;
  logic frame_end;
  logic [3:0] frame_len;
  logic [7:0] next_control_two;
  logic standby_rise;
  logic [2:0] flag_prev;

  // Decode one register address against the bus address
  function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
    return a == reg_addr;
  endfunction

  // Zero-extend an 8-bit register onto the data bus
  function automatic logic [31:0] widen(input logic [7:0] v);
    return {24'h000000, v};
  endfunction

  // Single-cycle access phase: the slave answers at the first penable edge
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign status_read = rd_en && hit(paddr, sci_tx_pkg::addr_status_one);
  assign data_write = wr_en && hit(paddr, sci_tx_pkg::addr_data);
  assign tx_en_rise = wr_en && hit(paddr, sci_tx_pkg::addr_control_two) &&
    pwdata[sci_tx_pkg::tx_enable_pos] && !control_two[sci_tx_pkg::tx_enable_pos];
  assign break_write_one = wr_en && hit(paddr, sci_tx_pkg::addr_control_two) &&
    pwdata[sci_tx_pkg::break_pos];
  assign frame_len = control_one[sci_tx_pkg::long_frame_pos] ?
    sci_tx_pkg::frame_long : sci_tx_pkg::frame_short;
  assign bit_tick = (baud_cnt == 8'h00);
  assign frame_end = bit_tick && (bit_cnt == 4'h1);
  // Shifter takes the buffer only when the transmitter is idle
  assign load_shifter = control_two[sci_tx_pkg::tx_enable_pos] && !tx_buffer_empty &&
    !tx_en_rise && (tx_state == sci_tx_pkg::tx_idle);
  // Standby bit about to go from zero to one
  assign standby_rise = next_control_two[sci_tx_pkg::standby_pos] &&
    !control_two[sci_tx_pkg::standby_pos];

  // Control two; software sets standby, hardware clears it on wakeup
  always_comb begin
    next_control_two = control_two;
    if (wr_en && hit(paddr, sci_tx_pkg::addr_control_two)) begin
      next_control_two = pwdata[7:0];
      // Writing zero cannot pull the receiver out of standby early
      next_control_two[sci_tx_pkg::standby_pos] = control_two[sci_tx_pkg::standby_pos] |
        pwdata[sci_tx_pkg::standby_pos];
    end
    if (wakeup) begin
      next_control_two[sci_tx_pkg::standby_pos] = 1'b0;
    end
  end

  // Configuration registers; control two loads next_control_two, the rest are plain read/write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_two <= 8'h00;
      control_one <= 8'h00;
      baud <= sci_tx_pkg::baud_reset;
      irq_enable <= 3'h0;
    end else begin
      control_two <= next_control_two;
      if (wr_en && hit(paddr, sci_tx_pkg::addr_control_one)) begin
        control_one <= pwdata[7:0];
      end
      if (wr_en && hit(paddr, sci_tx_pkg::addr_baud)) begin
        baud <= pwdata[7:0];
      end
      if (wr_en && hit(paddr, sci_tx_pkg::addr_irq_enable)) begin
        irq_enable <= pwdata[2:0];
      end
    end
  end

  // Buffer empty flag with its two-step clear; a status write never touches it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buffer_empty <= 1'b1;
      buf_armed <= 1'b0;
      data_buf <= 8'h00;
    end else begin
      if (status_read && tx_buffer_empty) begin
        buf_armed <= 1'b1;
      end else if (data_write) begin
        buf_armed <= 1'b0;
      end
      if (data_write) begin
        data_buf <= pwdata[7:0];
      end
      // Load wins over the clear, so an empty event is never lost
      if (load_shifter) begin
        tx_buffer_empty <= 1'b1;
      end else if (data_write && buf_armed) begin
        tx_buffer_empty <= 1'b0;
      end
    end
  end

  // Complete flag; cleared only after a read that saw it set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_complete_flag <= 1'b1;
      complete_armed <= 1'b0;
    end else begin
      if (status_read && tx_complete_flag) begin
        complete_armed <= 1'b1;
      end else if (data_write || tx_en_rise || break_write_one) begin
        complete_armed <= 1'b0;
      end
      if (complete_armed && (data_write || tx_en_rise || break_write_one)) begin
        tx_complete_flag <= 1'b0;
      end else if (tx_buffer_empty && tx_state == sci_tx_pkg::tx_idle &&
                   !break_latched) begin
        tx_complete_flag <= 1'b1;
      end
    end
  end

  // Break request latch: a one then zero still leaves one break queued
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_latched <= 1'b0;
    end else if (break_write_one) begin
      break_latched <= 1'b1;
    end else if (tx_state == sci_tx_pkg::tx_break && bit_cnt == frame_len &&
                 bit_tick && !control_two[sci_tx_pkg::break_pos]) begin
      break_latched <= 1'b0;
    end
  end

  // Transmitter: preamble, break and data frames, one bit per baud tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state <= sci_tx_pkg::tx_idle;
      shifter <= 9'h1ff;
      bit_cnt <= 4'h0;
      baud_cnt <= 8'h00;
      txd <= 1'b1;
    end else begin
      baud_cnt <= bit_tick ? baud : baud_cnt - 8'h01;
      case (tx_state)
        sci_tx_pkg::tx_idle: begin
          txd <= 1'b1;
          baud_cnt <= baud;
          if (tx_en_rise) begin
            tx_state <= sci_tx_pkg::tx_preamble;
            bit_cnt <= frame_len;
          end else if (control_two[sci_tx_pkg::tx_enable_pos] && break_latched) begin
            tx_state <= sci_tx_pkg::tx_break;
            bit_cnt <= frame_len;
            txd <= 1'b0;
          end else if (load_shifter) begin
            tx_state <= sci_tx_pkg::tx_data;
            shifter <= {1'b1, data_buf};
            bit_cnt <= frame_len;
            txd <= 1'b0;
          end
        end
        sci_tx_pkg::tx_data: begin
          if (bit_tick) begin
            txd <= shifter[0];
            shifter <= {1'b1, shifter[8:1]};
            bit_cnt <= bit_cnt - 4'h1;
            if (frame_end) begin
              tx_state <= sci_tx_pkg::tx_idle;
            end
          end
        end
        sci_tx_pkg::tx_preamble: begin
          txd <= 1'b1;
          if (bit_tick) begin
            bit_cnt <= bit_cnt - 4'h1;
            if (frame_end) begin
              tx_state <= sci_tx_pkg::tx_idle;
            end
          end
        end
        sci_tx_pkg::tx_break: begin
          txd <= 1'b0;
          if (bit_tick) begin
            bit_cnt <= bit_cnt - 4'h1;
            // Bit still set at frame end queues another break
            if (frame_end && control_two[sci_tx_pkg::break_pos]) begin
              bit_cnt <= frame_len;
            end else if (frame_end) begin
              // Release the line on the last tick so a break is exactly one frame long
              tx_state <= sci_tx_pkg::tx_idle;
              txd <= 1'b1;
            end
          end
        end
        default: begin
          tx_state <= sci_tx_pkg::tx_idle;
        end
      endcase
    end
  end

  // Receiver framing only as far as wakeup needs: idle count and data MSB
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_busy <= 1'b0;
      rx_cnt <= 4'h0;
      rx_baud_cnt <= 8'h00;
      idle_cnt <= 4'h0;
      rx_msb <= 1'b0;
      rx_prev <= 1'b1;
      wakeup <= 1'b0;
    end else begin
      rx_prev <= rxd;
      wakeup <= 1'b0;
      rx_baud_cnt <= (rx_baud_cnt == 8'h00) ? baud : rx_baud_cnt - 8'h01;
      if (!rx_busy && rx_prev && !rxd) begin
        rx_busy <= 1'b1;
        rx_cnt <= frame_len;
        // Half a bit first, so every later tick lands mid-bit
        rx_baud_cnt <= {1'b0, baud[7:1]};
        idle_cnt <= 4'h0;
      end else if (rx_busy && rx_baud_cnt == 8'h00) begin
        rx_cnt <= rx_cnt - 4'h1;
        // Last data bit sits just before the stop bit
        if (rx_cnt == 4'h2) begin
          rx_msb <= rxd;
        end
        if (rx_cnt == 4'h1) begin
          rx_busy <= 1'b0;
          // Address mark wakeup looks at the top data bit
          if (control_one[sci_tx_pkg::resume_method_pos] && rx_msb &&
              control_two[sci_tx_pkg::standby_pos]) begin
            wakeup <= 1'b1;
          end
        end
      end else if (!rx_busy && rxd && rx_baud_cnt == 8'h00) begin
        if (idle_cnt != sci_tx_pkg::idle_bits) begin
          idle_cnt <= idle_cnt + 4'h1;
        end
        if (idle_cnt == sci_tx_pkg::idle_bits - 4'h1 &&
            !control_one[sci_tx_pkg::resume_method_pos] &&
            control_two[sci_tx_pkg::standby_pos]) begin
          wakeup <= 1'b1;
        end
      end
      // A fresh standby waits for a whole new idle character, not an old one
      if (standby_rise) begin
        idle_cnt <= 4'h0;
      end
    end
  end

  // Sticky event bits set on a rising flag; set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= 3'h0;
      flag_prev <= 3'h0; // Flags set out of reset count as events
    end else begin
      flag_prev <= {wakeup, tx_complete_flag, tx_buffer_empty};
      irq_status <= (irq_status & ~((wr_en && hit(paddr, sci_tx_pkg::addr_irq_clear)) ?
        pwdata[2:0] : 3'h0)) | ({wakeup, tx_complete_flag, tx_buffer_empty} & ~flag_prev);
    end
  end

  // Outputs from flops: interrupt level, standby mirror, APB answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
      rx_standby <= 1'b0;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_enable);
      rx_standby <= control_two[sci_tx_pkg::standby_pos];
      // Ready registered from the setup cycle so the access phase completes at once
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        pslverr <= !(hit(paddr, sci_tx_pkg::addr_control_two) ||
          hit(paddr, sci_tx_pkg::addr_status_one) || hit(paddr, sci_tx_pkg::addr_data) ||
          hit(paddr, sci_tx_pkg::addr_control_one) || hit(paddr, sci_tx_pkg::addr_baud) ||
          hit(paddr, sci_tx_pkg::addr_irq_status) || hit(paddr, sci_tx_pkg::addr_irq_enable) ||
          hit(paddr, sci_tx_pkg::addr_irq_clear));
        case (paddr)
          sci_tx_pkg::addr_control_two: prdata <= widen(control_two);
          // Status flags are read only; a write here changes nothing
          sci_tx_pkg::addr_status_one: prdata <= widen({tx_buffer_empty, tx_complete_flag,
            1'b0, (idle_cnt == sci_tx_pkg::idle_bits), 4'h0});
          sci_tx_pkg::addr_data: prdata <= widen(data_buf);
          sci_tx_pkg::addr_control_one: prdata <= widen(control_one);
          sci_tx_pkg::addr_baud: prdata <= widen(baud);
          sci_tx_pkg::addr_irq_status: prdata <= widen({5'h00, irq_status});
          sci_tx_pkg::addr_irq_enable: prdata <= widen({5'h00, irq_enable});
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // sci_tx_status

// ===== verification/sci_tx_status_sva.sv
// Port checker for the serial transmit status block.
// Assumes one pclk domain and is bound onto every sci_tx_status.
module sci_tx_status_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rxd,
  input wire logic txd,
  input wire logic irq,
  input wire logic rx_standby
);
  logic wr_ctl;
  logic set_sb;
  // Completed writes to control two, and those that ask for standby
  assign wr_ctl = psel && penable && pready && pwrite && paddr == sci_tx_pkg::addr_control_two;
  assign set_sb = wr_ctl && pwdata[sci_tx_pkg::standby_pos];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_follows: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_err_unmapped: assert property (pready && paddr > sci_tx_pkg::addr_irq_clear |-> pslverr)
    else $error("unmapped access not refused");
  chk_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  chk_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_standby_set: assert property (set_sb |-> ##[1:2] rx_standby)
    else $error("standby not entered");
  chk_standby_keep: assert property (rx_standby && wr_ctl && !pwdata[1] |-> ##2 rx_standby)
    else $error("software cleared standby");
  chk_standby_cause: assert property ($rose(rx_standby) |-> $past(set_sb) || $past(set_sb, 2))
    else $error("standby without request");
endmodule // sci_tx_status_chk

bind sci_tx_status sci_tx_status_chk chk_i (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .rxd, .txd, .irq, .rx_standby);

// ===== verification/serial_far_end.sv
// Remote serial transmitter that drives the block's receive line.
// Assumes the bench pulses go for one cycle with the character held.
module serial_far_end #(
  parameter int bit_time = 5
) (
  input wire logic pclk,
  input wire logic go,
  input wire logic [7:0] byte_in,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] frame;
  initial rxd = 1'b1;
  // Start, data LSB first, stop; the line idles high between frames
  always @(posedge pclk) begin
    if (go) begin
      frame = {1'b1, byte_in, 1'b0};
      for (int i = 0; i < 10; i++) begin
        rxd <= frame[i];
        repeat (bit_time) @(posedge pclk);
      end
      rxd <= 1'b1;
    end
  end
endmodule // serial_far_end

// ===== verification/tb.sv
// Self-checking bench for the serial transmit status block.
// Assumes the reset baud value, so one bit time is five pclk cycles.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int bt = 5;
  typedef struct {logic [7:0] a; logic [31:0] d; logic e;} row_t;
  row_t rows [5] = '{'{sci_tx_pkg::addr_status_one, 32'hc0, 1'b0},
    '{sci_tx_pkg::addr_control_two, 32'h0, 1'b0}, '{sci_tx_pkg::addr_baud, 32'h4, 1'b0},
    '{sci_tx_pkg::addr_irq_enable, 32'h0, 1'b0}, '{8'h20, 32'h0, 1'b1}};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic go = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [7:0] far_byte = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, rxd, txd, irq, rx_standby, err;
  int n_fail = 0;
  int cmp_count = 0;
  int n, low_run = 0, last_low = 0;
  always #2.5 pclk = ~pclk;
  sci_tx_status uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rxd, .txd, .irq, .rx_standby);
  serial_far_end #(.bit_time(bt)) far (.pclk, .go, .byte_in(far_byte), .rxd);
  // Length of the last low run on txd, for break timing
  always @(posedge pclk) begin
    if (txd === 1'b0) low_run <= low_run + 1;
    else if (low_run != 0) begin
      last_low <= low_run;
      low_run <= 0;
    end
  end
  task stop_test;
    $display("compares %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  // One APB transfer; request held until pready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Read until the masked value appears; a bounded count guards a hang
  task poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    int i;
    i = 0;
    do begin
      apb(1'b0, a, 32'h0);
      i++;
    end while ((rd & m) !== v && i < 80);
    check(rd & m, v, "polled value");
  endtask
  task wait_txd(input logic lvl);
    n = 0;
    while (txd !== lvl && n < 400) begin
      @(posedge pclk);
      n++;
    end
    if (txd !== lvl) begin
      n_fail++;
      stop_test();
    end
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b0, rows[i].a, 32'h0);
      check(rd, rows[i].d, "reset read");
      check({31'h0, err}, {31'h0, rows[i].e}, "slave error");
    end
    $display("reset values done");
    apb(1'b1, sci_tx_pkg::addr_status_one, 32'h0);
    apb(1'b0, sci_tx_pkg::addr_status_one, 32'h0);
    check(rd & 32'hc0, 32'hc0, "status written");
    check({31'h0, irq}, 32'h0, "masked irq");
    apb(1'b1, sci_tx_pkg::addr_irq_enable, 32'h3);
    repeat (3) @(posedge pclk);
    check({31'h0, irq}, 32'h1, "enabled irq");
    apb(1'b1, sci_tx_pkg::addr_irq_clear, 32'h3);
    apb(1'b1, sci_tx_pkg::addr_irq_enable, 32'h4);
    apb(1'b0, sci_tx_pkg::addr_irq_status, 32'h0);
    check(rd & 32'h3, 32'h0, "irq cleared");
    check({31'h0, irq}, 32'h0, "irq after clear");
    $display("irq done");
    // Status read then data write clears both flags; enable then sends
    apb(1'b1, sci_tx_pkg::addr_data, 32'ha5);
    apb(1'b0, sci_tx_pkg::addr_status_one, 32'h0);
    check(rd & 32'hc0, 32'h0, "flags after data write");
    apb(1'b1, sci_tx_pkg::addr_control_two, 32'h8);
    wait_txd(1'b0);
    check({31'h0, n >= 10 * bt && n <= 11 * bt}, 32'h1, "preamble length");
    apb(1'b0, sci_tx_pkg::addr_status_one, 32'h0);
    check(rd & 32'hc0, 32'h80, "loaded and active");
    poll(sci_tx_pkg::addr_status_one, 32'hc0, 32'hc0);
    $display("transmit done");
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, sci_tx_pkg::addr_control_one, 32'(k) << sci_tx_pkg::long_frame_pos);
      apb(1'b0, sci_tx_pkg::addr_status_one, 32'h0);
      apb(1'b1, sci_tx_pkg::addr_control_two, 32'h9);
      apb(1'b0, sci_tx_pkg::addr_status_one, 32'h0);
      check(rd & 32'h40, 32'h0, "complete on break");
      apb(1'b1, sci_tx_pkg::addr_control_two, 32'h8);
      wait_txd(1'b0);
      wait_txd(1'b1);
      @(posedge pclk);
      n = (10 + k) * bt;
      check({31'h0, last_low == n || last_low == 2 * n}, 32'h1, "break length");
      poll(sci_tx_pkg::addr_status_one, 32'h40, 32'h40);
    end
    $display("break done");
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, sci_tx_pkg::addr_control_one, 32'(m) << sci_tx_pkg::resume_method_pos);
      apb(1'b1, sci_tx_pkg::addr_control_two, 32'ha);
      repeat (2) @(posedge pclk);
      check({31'h0, rx_standby}, 32'h1, "standby entered");
      apb(1'b1, sci_tx_pkg::addr_control_two, 32'h8);
      check({31'h0, rx_standby}, 32'h1, "standby kept");
      if (m == 1) begin
        far_byte <= 8'h7f;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        repeat (12 * bt) @(posedge pclk);
        check({31'h0, rx_standby}, 32'h1, "no mark no wake");
        far_byte <= 8'h80;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
      end
      poll(sci_tx_pkg::addr_control_two, 32'h2, 32'h0);
      repeat (2) @(posedge pclk);
      check({31'h0, rx_standby}, 32'h0, "standby left");
    end
    apb(1'b0, sci_tx_pkg::addr_irq_status, 32'h0);
    check(rd & 32'h4, 32'h4, "wakeup event");
    $display("standby done");
    // Reset as a data write lands, before the shifter loads, then an enable edge clears complete and sends a preamble
    apb(1'b0, sci_tx_pkg::addr_status_one, 32'h0);
    apb(1'b1, sci_tx_pkg::addr_data, 32'h5a);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, sci_tx_pkg::addr_status_one, 32'h0);
    check(rd & 32'hc0, 32'hc0, "flags after reset");
    apb(1'b1, sci_tx_pkg::addr_control_two, 32'h8);
    apb(1'b0, sci_tx_pkg::addr_status_one, 32'h0);
    check(rd & 32'hc0, 32'h80, "complete on enable");
    $display("reset done");
    stop_test();
  end
endmodule // tb
